// ===== pdm_pkg.sv
// shared constants and carriers for the program/data address map
package pdm_pkg;
   // special register addresses
   localparam logic [7:0] ADR_PAGE_CTL  = 8'h80;
   localparam logic [7:0] ADR_SP        = 8'h81;
   localparam logic [7:0] ADR_PTR_LO    = 8'h82;
   localparam logic [7:0] ADR_PTR_HI    = 8'h83;
   localparam logic [7:0] ADR_PORT1     = 8'h90;
   localparam logic [7:0] ADR_SERBUF    = 8'h99;
   localparam logic [7:0] ADR_P3MODE    = 8'h9C;
   localparam logic [7:0] ADR_P4MODE    = 8'h9D;
   localparam logic [7:0] ADR_P5MODE    = 8'h9E;
   localparam logic [7:0] ADR_HI_PAGE   = 8'hA0;
   localparam logic [7:0] ADR_AUX_CONTROL_ONE      = 8'hA2;
   localparam logic [7:0] ADR_PORT3     = 8'hB0;
   localparam logic [7:0] ADR_PORT4     = 8'hC0;
   localparam logic [7:0] ADR_PORT5     = 8'hC4;
   localparam logic [7:0] ADR_PSW       = 8'hD0;
   localparam logic [7:0] ADR_ACC       = 8'hE0;
   localparam logic [7:0] ADR_MULB      = 8'hF0;
   // reset values
   localparam logic [7:0] RST_SP        = 8'h07;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   // field positions
   localparam int PSEL_HI   = 7;
   localparam int PSEL_LO   = 6;
   localparam int PSW_RSHI  = 4;
   localparam int PSW_RSLO  = 3;
   localparam int AUX_SOFT_RESET_BIT  = 5;
   localparam int AUX_GF2   = 4;
   localparam int AUX_POWERDOWN_WAKE_ENABLE  = 3;
   localparam int AUX_ZERO  = 2;
   localparam int AUX_DPS   = 0;
   localparam logic [7:0] AUX_WMASK = 8'h39;
   localparam logic [7:0] SFR_TOP  = 8'h80;
   localparam logic [7:0] BIT_BASE = 8'h20;
   localparam logic [7:0] PORT3_RD_BIT = 8'h07;
   localparam logic [7:0] PORT3_WR_BIT = 8'h06;
   localparam logic [7:0] UNMAPPED_RD  = 8'h00;
   // internal memory sizes
   localparam int LOW_BYTES = 128;
   localparam int UP_BYTES  = 128;
   localparam int PA_W      = 17;

   typedef enum logic [1:0] {
      SZ_32K = 2'b00,
      SZ_48K = 2'b01,
      SZ_56K = 2'b10,
      SZ_64K = 2'b11
   } pdm_size_e;

   typedef struct packed {
      logic       dir;   // direct access (else indirect)
      logic       wr;
      logic       rd;
      logic [7:0] adr;
      logic [7:0] wdat;
   } pdm_iacc_s;

   typedef struct packed {
      logic       bit_wr;
      logic       bit_rd;
      logic [7:0] badr;
      logic       bval;
   } pdm_bacc_s;
endpackage : pdm_pkg

// ===== pdm_prog_map.sv
// program counter to physical sram address translation
`timescale 1ns/100ps
`default_nettype none
module pdm_prog_map (
   // page control and counter
   input  wire logic [7:0]                   page_ctl,
   input  wire logic [15:0]                  pc,
   // physical address
   output var  logic [pdm_pkg::PA_W-1:0]     phys
);
   logic [16:0] common;
   logic [16:0] ext;
   logic [5:0]  page;
   always_comb begin
      page = page_ctl[5:0];
      unique case (pdm_pkg::pdm_size_e'(page_ctl[pdm_pkg::PSEL_HI:pdm_pkg::PSEL_LO]))
         pdm_pkg::SZ_64K: begin
            common = 17'h1_0000;
            ext    = 17'h0_0000;
         end
         pdm_pkg::SZ_56K: begin
            common = 17'h0_E000;
            ext    = 17'h0_2000;
         end
         pdm_pkg::SZ_48K: begin
            common = 17'h0_C000;
            ext    = 17'h0_4000;
         end
         pdm_pkg::SZ_32K: begin
            common = 17'h0_8000;
            ext    = 17'h0_8000;
         end
      endcase
      // page product kept at 17 bits; overflow past 128KB wraps
      if ({1'b0, pc} < common) begin
         phys = {1'b0, pc};
      end else begin
         phys = 17'({1'b0, pc} + 17'(ext * {11'h000, page}));
      end
   end
endmodule // pdm_prog_map
`default_nettype wire

// ===== pdm_iram.sv
// 256-byte internal ram: lower block and indirect-only upper block
`timescale 1ns/100ps
`default_nettype none
module pdm_iram (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // access
   input  wire logic        we,
   input  wire logic [7:0]  wadr,
   input  wire logic [7:0]  wdat,
   input  wire logic [7:0]  radr,
   output var  logic [7:0]  rdat
);
   // memory contents carry no reset, like the sram they model
   logic [7:0] mem [0:pdm_pkg::LOW_BYTES+pdm_pkg::UP_BYTES-1];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[wadr] <= wdat;
      end
   end
   always_comb begin
      rdat = mem[radr];
   end
   logic unused_nrst;
   assign unused_nrst = nrst;
endmodule // pdm_iram
`default_nettype wire

// ===== pdm_top.sv
// What this block does
// - fetch address built from page-size bits, page number and counter
// - size bits pick extended/common: 11 0/64K, 10 8/56K, 01 16/48K, 00 32/32K
// - counter below common size passes; else add page times extended size
// - page number ignored inside common space
// - physical program address is seventeen bits
// - 384 internal bytes: lower, upper and special register blocks
// - above 7FH: direct hits special registers, indirect hits upper ram
// - lower reachable both ways, upper indirect only, registers direct only
// - lowest 32 bytes are four banks of eight, chosen by status bits
// - 16 bytes above banks are bit addressable, bits 00H-7FH
// - registers at addresses ending 0 or 8 are bit addressable
// - unimplemented registers read undefined; software must not write them
// - status word: carry, aux carry, flag0, bank hi, bank lo, overflow, flag1, parity
// - stack pointer resets to 07H, reloadable to any location
// - aux control: soft reset b5, flag b4, wake enable b3, zero b2, select b0
// - wake enable gates external interrupt wake from power down
// - one pointer address reaches two 16-bit pointers by select bit
// - port bits drive pins; write one before using pin as input
// - mode bits set push-pull, clear keeps pseudo-bidirectional
// - 8-bit indirect external moves take high byte from page register
// - serial buffer write loads transmit and starts; read gives receive
// - core drives internal read/write strobes on port three bits 7 and 6
`timescale 1ns/100ps
`default_nettype none
module pdm_top (
   // clock and reset
   input  wire logic                      CLK,
   input  wire logic                      NRST,
   // program fetch
   input  wire logic [15:0]               PC,
   output var  logic [16:0]               PROG_ADDR,
   // internal data access
   input  wire pdm_pkg::pdm_iacc_s        IACC,
   output var  logic [7:0]                IRDATA,
   // bit access
   input  wire pdm_pkg::pdm_bacc_s        BACC,
   output var  logic                      BIT_RDATA,
   // register bank operand
   input  wire logic [2:0]                REG_NUM,
   output var  logic [7:0]                REG_ADDR,
   // core flag, stack and pointer updates
   input  wire logic                      FLAGS_WE,
   input  wire logic [7:0]                FLAGS_IN,
   input  wire logic                      SP_WE,
   input  wire logic [7:0]                SP_IN,
   input  wire logic                      PTR_INC,
   // external data moves
   input  wire logic                      XMOV_RI,
   input  wire logic [7:0]                XRI_LOW,
   input  wire logic                      XRD_REQ,
   input  wire logic                      XWR_REQ,
   output var  logic [15:0]               XDATA_ADDR,
   output var  logic                      XRD_STB,
   output var  logic                      XWR_STB,
   // serial buffer
   input  wire logic [7:0]                RX_BYTE,
   output var  logic [7:0]                TX_BYTE,
   output var  logic                      TX_START,
   // power and reset control
   input  wire logic                      EXT_IRQ,
   input  wire logic                      POWERED_DOWN,
   output var  logic                      WAKE,
   output var  logic                      SOFT_RST,
   // ports
   output var  logic [7:0]                PORT1_OUT,
   output var  logic [7:0]                PORT3_OUT,
   output var  logic [7:0]                PORT4_OUT,
   output var  logic [7:0]                PORT5_OUT,
   output var  logic [23:0]               PUSH_PULL
);
   typedef struct packed {
      logic [7:0]  page_ctl;
      logic [7:0]  sp;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [7:0]  p1;
      logic [7:0]  p3;
      logic [7:0]  p3o;
      logic [7:0]  p4;
      logic [7:0]  p5;
      logic [7:0]  m3;
      logic [7:0]  m4;
      logic [7:0]  m5;
      logic [7:0]  hipage;
      logic [7:0]  aux;
      logic [7:0]  program_status_word;
      logic [7:0]  acc;
      logic [7:0]  mulb;
      logic [7:0]  txb;
      logic        txs;
      logic        wake;
      logic        xrd;
      logic        xwr;
      logic [15:0] xadr;
      logic [16:0] paddr;
      logic [7:0]  regadr;
      logic [7:0]  rdat;
      logic        brd;
   } pdm_state_s;

   pdm_state_s s_q;
   pdm_state_s s_d;

   logic [16:0] phys;
   logic [7:0]  ram_rdat;
   logic        ram_we;
   logic [7:0]  ram_wadr;
   logic [7:0]  ram_wdat;
   logic [7:0]  ram_radr;
   logic        sfr_sel;
   logic [7:0]  sfr_rd;
   logic [15:0] cur_ptr;
   logic [7:0]  bit_byte;
   logic        bit_sfr;
   logic [7:0]  sfr_w;
   logic [7:0]  sfr_wd;
   logic        sfr_we;

   pdm_prog_map u_map (
      .page_ctl (s_q.page_ctl),
      .pc       (PC),
      .phys     (phys)
   );

   pdm_iram u_ram (
      .clk  (CLK),
      .nrst (NRST),
      .we   (ram_we),
      .wadr (ram_wadr),
      .wdat (ram_wdat),
      .radr (ram_radr),
      .rdat (ram_rdat)
   );

   // special register read mux
   function automatic logic [7:0] sfr_read(input pdm_state_s st, input logic [7:0] a, input logic [7:0] rx);
      logic [15:0] p;
      p = st.aux[pdm_pkg::AUX_DPS] ? st.ptr1 : st.ptr0;
      unique case (a)
         pdm_pkg::ADR_PAGE_CTL: sfr_read = st.page_ctl;
         pdm_pkg::ADR_SP:       sfr_read = st.sp;
         pdm_pkg::ADR_PTR_LO:   sfr_read = p[7:0];
         pdm_pkg::ADR_PTR_HI:   sfr_read = p[15:8];
         pdm_pkg::ADR_PORT1:    sfr_read = st.p1;
         pdm_pkg::ADR_SERBUF:   sfr_read = rx;
         pdm_pkg::ADR_P3MODE:   sfr_read = st.m3;
         pdm_pkg::ADR_P4MODE:   sfr_read = st.m4;
         pdm_pkg::ADR_P5MODE:   sfr_read = st.m5;
         pdm_pkg::ADR_HI_PAGE:  sfr_read = st.hipage;
         pdm_pkg::ADR_AUX_CONTROL_ONE:     sfr_read = st.aux;
         pdm_pkg::ADR_PORT3:    sfr_read = st.p3;
         pdm_pkg::ADR_PORT4:    sfr_read = st.p4;
         pdm_pkg::ADR_PORT5:    sfr_read = st.p5;
         pdm_pkg::ADR_PSW:      sfr_read = st.program_status_word;
         pdm_pkg::ADR_ACC:      sfr_read = st.acc;
         pdm_pkg::ADR_MULB:     sfr_read = st.mulb;
         default:               sfr_read = pdm_pkg::UNMAPPED_RD;
      endcase
   endfunction

   always_comb begin
      s_d      = s_q;
      cur_ptr  = s_q.aux[pdm_pkg::AUX_DPS] ? s_q.ptr1 : s_q.ptr0;
      s_d.txs  = 1'b0;
      // byte access: direct above 7FH goes to registers, indirect to upper ram
      sfr_sel  = IACC.dir && (IACC.adr >= pdm_pkg::SFR_TOP);
      // bit address: low half maps into 20H-2FH, high half into x0/x8 registers
      bit_sfr  = BACC.badr[7];
      bit_byte = bit_sfr ? {BACC.badr[7:3], 3'b000}
                         : 8'(pdm_pkg::BIT_BASE + {3'b000, BACC.badr[7:3]});
      ram_radr = (BACC.bit_rd || BACC.bit_wr) ? bit_byte : IACC.adr;
      sfr_rd   = sfr_read(s_q, (BACC.bit_rd || BACC.bit_wr) ? bit_byte : IACC.adr, RX_BYTE);
      // unify byte and bit writes; bit write is read-modify-write within a cycle
      ram_we   = 1'b0;
      ram_wadr = IACC.adr;
      ram_wdat = IACC.wdat;
      sfr_we   = 1'b0;
      sfr_w    = IACC.adr;
      sfr_wd   = IACC.wdat;
      if (BACC.bit_wr) begin
         if (bit_sfr) begin
            sfr_we = 1'b1;
            sfr_w  = bit_byte;
            sfr_wd = sfr_rd;
            sfr_wd[BACC.badr[2:0]] = BACC.bval;
         end else begin
            ram_we   = 1'b1;
            ram_wadr = bit_byte;
            ram_wdat = ram_rdat;
            ram_wdat[BACC.badr[2:0]] = BACC.bval;
         end
      end else if (IACC.wr) begin
         sfr_we = sfr_sel;
         ram_we = !sfr_sel;
      end
      if (sfr_we) begin
         unique case (sfr_w)
            pdm_pkg::ADR_PAGE_CTL: s_d.page_ctl = sfr_wd;
            pdm_pkg::ADR_SP:       s_d.sp = sfr_wd;
            pdm_pkg::ADR_PTR_LO: begin
               if (s_q.aux[pdm_pkg::AUX_DPS]) s_d.ptr1[7:0] = sfr_wd;
               else s_d.ptr0[7:0] = sfr_wd;
            end
            pdm_pkg::ADR_PTR_HI: begin
               if (s_q.aux[pdm_pkg::AUX_DPS]) s_d.ptr1[15:8] = sfr_wd;
               else s_d.ptr0[15:8] = sfr_wd;
            end
            pdm_pkg::ADR_PORT1:    s_d.p1 = sfr_wd;
            pdm_pkg::ADR_SERBUF: begin
               s_d.txb = sfr_wd;
               s_d.txs = 1'b1;
            end
            pdm_pkg::ADR_P3MODE:   s_d.m3 = sfr_wd;
            pdm_pkg::ADR_P4MODE:   s_d.m4 = sfr_wd;
            pdm_pkg::ADR_P5MODE:   s_d.m5 = sfr_wd;
            pdm_pkg::ADR_HI_PAGE:  s_d.hipage = sfr_wd;
            pdm_pkg::ADR_AUX_CONTROL_ONE:     s_d.aux = sfr_wd & pdm_pkg::AUX_WMASK;
            pdm_pkg::ADR_PORT3:    s_d.p3 = sfr_wd;
            pdm_pkg::ADR_PORT4:    s_d.p4 = sfr_wd;
            pdm_pkg::ADR_PORT5:    s_d.p5 = sfr_wd;
            pdm_pkg::ADR_PSW:      s_d.program_status_word = sfr_wd;
            pdm_pkg::ADR_ACC:      s_d.acc = sfr_wd;
            pdm_pkg::ADR_MULB:     s_d.mulb = sfr_wd;
            default: ; // writes to empty slots are dropped
         endcase
      end
      // core flag and stack updates win over a same-cycle software write
      if (FLAGS_WE) s_d.program_status_word = FLAGS_IN;
      if (SP_WE) s_d.sp = SP_IN;
      if (PTR_INC) begin
         if (s_q.aux[pdm_pkg::AUX_DPS]) s_d.ptr1 = 16'(cur_ptr + 16'h0001);
         else s_d.ptr0 = 16'(cur_ptr + 16'h0001);
      end
      // parity always follows the accumulator
      s_d.program_status_word[0] = ^s_d.acc;
      s_d.aux[pdm_pkg::AUX_ZERO] = 1'b0;
      s_d.wake = POWERED_DOWN && EXT_IRQ && s_q.aux[pdm_pkg::AUX_POWERDOWN_WAKE_ENABLE];
      // external data address: 8-bit indirect uses high page byte
      s_d.xadr = XMOV_RI ? {s_q.hipage, XRI_LOW} : cur_ptr;
      s_d.xrd = XRD_REQ;
      s_d.xwr = XWR_REQ;
      // strobes replace port three bits 7 and 6 while active; registered so the pin has no glitch
      s_d.p3o = {s_d.p3[7] & ~s_d.xrd, s_d.p3[6] & ~s_d.xwr, s_d.p3[5:0]};
      s_d.paddr = phys;
      s_d.regadr = {3'b000, s_q.program_status_word[pdm_pkg::PSW_RSHI:pdm_pkg::PSW_RSLO], REG_NUM};
      s_d.rdat = sfr_sel ? sfr_rd : ram_rdat;
      s_d.brd = bit_sfr ? sfr_rd[BACC.badr[2:0]] : ram_rdat[BACC.badr[2:0]];
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_q    <= '0;
         s_q.sp <= pdm_pkg::RST_SP;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      PROG_ADDR  = s_q.paddr;
      IRDATA     = s_q.rdat;
      BIT_RDATA  = s_q.brd;
      REG_ADDR   = s_q.regadr;
      XDATA_ADDR = s_q.xadr;
      XRD_STB    = s_q.xrd;
      XWR_STB    = s_q.xwr;
      TX_BYTE    = s_q.txb;
      TX_START   = s_q.txs;
      WAKE       = s_q.wake;
      SOFT_RST   = s_q.aux[pdm_pkg::AUX_SOFT_RESET_BIT];
      PORT1_OUT  = s_q.p1;
      PORT3_OUT  = s_q.p3o;
      PORT4_OUT  = s_q.p4;
      PORT5_OUT  = s_q.p5;
      PUSH_PULL  = {s_q.m5, s_q.m4, s_q.m3};
   end
endmodule // pdm_top
`default_nettype wire

// ===== pdm_top_props.sv
// concurrent checks on the address map top ports
`timescale 1ns/100ps
`default_nettype none
module pdm_top_props (
   // clock and reset
   input wire logic               CLK,
   input wire logic               NRST,
   // watched ports
   input wire logic [15:0]        PC,
   input wire logic [16:0]        PROG_ADDR,
   input wire pdm_pkg::pdm_iacc_s IACC,
   input wire logic [7:0]         IRDATA,
   input wire logic [2:0]         REG_NUM,
   input wire logic [7:0]         REG_ADDR,
   input wire logic               FLAGS_WE,
   input wire logic [7:0]         FLAGS_IN,
   input wire logic               XMOV_RI,
   input wire logic [7:0]         XRI_LOW,
   input wire logic               XRD_REQ,
   input wire logic [15:0]        XDATA_ADDR,
   input wire logic               XRD_STB,
   input wire logic [7:0]         RX_BYTE,
   input wire logic [7:0]         TX_BYTE,
   input wire logic               TX_START,
   input wire logic               EXT_IRQ,
   input wire logic               POWERED_DOWN,
   input wire logic               WAKE,
   input wire logic [7:0]         PORT1_OUT,
   input wire logic [7:0]         PORT3_OUT
);
   logic [7:0]  page_q, hi_q, aux_q;
   logic [1:0]  bank_q;
   logic [16:0] exp_q, ext;
   logic        dwr;
   assign dwr = IACC.wr && IACC.dir;
   assign ext = (page_q[7:6] == 2'b11) ? 17'h0_0000 : 17'h0_8000 >> page_q[7:6];
   // shadows follow byte writes, and the bank shadow also core flag loads; bit writes to these registers would fool them
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         page_q <= 8'h00;
         hi_q   <= 8'h00;
         aux_q  <= 8'h00;
         bank_q <= 2'b00;
         exp_q  <= 17'h0_0000;
      end else begin
         if (dwr && IACC.adr == 8'h80) page_q <= IACC.wdat;
         if (dwr && IACC.adr == 8'hA0) hi_q <= IACC.wdat;
         if (dwr && IACC.adr == 8'hA2) aux_q <= IACC.wdat;
         if (FLAGS_WE) bank_q <= FLAGS_IN[4:3];
         else if (dwr && IACC.adr == 8'hD0) bank_q <= IACC.wdat[4:3];
         exp_q <= ({1'b0, PC} < 17'h1_0000 - ext) ? {1'b0, PC} : 17'({1'b0, PC} + page_q[5:0] * ext);
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   prog_map_a: assert property (PROG_ADDR == exp_q)
      else $error("program address mismatch");
   tx_load_a: assert property (dwr && IACC.adr == 8'h99 |=> TX_START && TX_BYTE == $past(IACC.wdat))
      else $error("serial write did not load and start");
   tx_cause_a: assert property (TX_START |-> $past(dwr && IACC.adr == 8'h99))
      else $error("transmit start without serial write");
   upper_indirect_a: assert property (IACC.wr && !IACC.dir && IACC.adr == 8'h99 |=> !TX_START)
      else $error("indirect upper write reached special register");
   rx_read_a: assert property (IACC.rd && IACC.dir && IACC.adr == 8'h99 |=> IRDATA == $past(RX_BYTE))
      else $error("serial read not from receive byte");
   xmov_addr_a: assert property (XMOV_RI |=> XDATA_ADDR == {$past(hi_q), $past(XRI_LOW)})
      else $error("indirect external address wrong");
   rd_strobe_a: assert property (XRD_REQ |=> XRD_STB && !PORT3_OUT[7])
      else $error("read strobe missing");
   wake_gate_a: assert property (EXT_IRQ && POWERED_DOWN |=> WAKE == $past(aux_q[3]))
      else $error("wake not gated by enable");
   bank_addr_a: assert property (1'b1 |=> REG_ADDR == {3'b000, $past(bank_q), $past(REG_NUM)})
      else $error("working register address wrong");
   port_latch_a: assert property (dwr && IACC.adr == 8'h90 |=> PORT1_OUT == $past(IACC.wdat))
      else $error("port latch not loaded");
   cover property (PC > 16'h7FFF && page_q[5:0] != 6'h00);
   cover property (WAKE);
   cover property (TX_START);
endmodule // pdm_top_props
bind pdm_top pdm_top_props pdm_top_props_inst (.CLK, .NRST, .PC, .PROG_ADDR, .IACC, .IRDATA, .REG_NUM, .REG_ADDR,
   .FLAGS_WE, .FLAGS_IN, .XMOV_RI, .XRI_LOW, .XRD_REQ, .XDATA_ADDR, .XRD_STB, .RX_BYTE, .TX_BYTE, .TX_START,
   .EXT_IRQ, .POWERED_DOWN, .WAKE, .PORT1_OUT, .PORT3_OUT);
`default_nettype wire

// ===== pdm_sram_model.sv
// shared sram stand-in noting data strobes from the core side
`timescale 1ns/100ps
`default_nettype none
module pdm_sram_model (
   // clock
   input  wire logic        CLK,
   // data access
   input  wire logic [15:0] XDATA_ADDR,
   input  wire logic        XRD_STB,
   input  wire logic        XWR_STB,
   // observation
   output var  logic [15:0] last_adr,
   output var  int          n_strobe
);
   initial n_strobe = 0;
   always @(posedge CLK) begin
      if (XRD_STB || XWR_STB) begin
         n_strobe <= n_strobe + 1;
         last_adr <= XDATA_ADDR;
      end
   end
endmodule // pdm_sram_model
`default_nettype wire

// ===== pdm_top_test.sv
// self-checking bench for the address map block
`timescale 1ns/100ps
`default_nettype none
module pdm_top_test;
   typedef struct {int due; int sel; logic [16:0] exp;} pdm_note_s;
   logic CLK = 0, NRST = 0, FLAGS_WE = 0, SP_WE = 0, PTR_INC = 0, XMOV_RI = 0;
   logic XRD_REQ = 0, XWR_REQ = 0, EXT_IRQ = 0, POWERED_DOWN = 0, BIT_RDATA, XRD_STB, XWR_STB, TX_START, WAKE, SOFT_RST;
   logic [15:0] PC = 16'h0000, XDATA_ADDR, last_adr;
   logic [7:0] FLAGS_IN = 8'h00, SP_IN = 8'h00, XRI_LOW = 8'h00, RX_BYTE = 8'h00, x, y, pg;
   logic [7:0] IRDATA, REG_ADDR, TX_BYTE, PORT1_OUT, PORT3_OUT, PORT4_OUT, PORT5_OUT;
   logic [2:0] REG_NUM = 3'h0, z;
   logic [16:0] PROG_ADDR, c;
   logic [23:0] PUSH_PULL;
   pdm_pkg::pdm_iacc_s IACC = '0;
   pdm_pkg::pdm_bacc_s BACC = '0;
   int n_mismatch = 0, comparisons = 0, ncyc = 0, ticks = 0, n_strobe;
   pdm_note_s notes[$], cur;
   logic [7:0] adr_t [7] = '{8'h90, 8'hB0, 8'hC0, 8'hC4, 8'h9C, 8'h9D, 8'h9E};
   string nm [18] = '{"PROG_ADDR", "IRDATA", "TX_BYTE", "XDATA_ADDR", "REG_ADDR", "WAKE", "PORT1_OUT", "PORT3_OUT",
      "PORT4_OUT", "PORT5_OUT", "PUSH_PULL3", "PUSH_PULL4", "PUSH_PULL5", "BIT_RDATA", "XRD_STB", "TX_START",
      "SOFT_RST", "XWR_STB"};
   pdm_top pdm_top_inst (.CLK, .NRST, .PC, .PROG_ADDR, .IACC, .IRDATA, .BACC, .BIT_RDATA, .REG_NUM, .REG_ADDR,
      .FLAGS_WE, .FLAGS_IN, .SP_WE, .SP_IN, .PTR_INC, .XMOV_RI, .XRI_LOW, .XRD_REQ, .XWR_REQ, .XDATA_ADDR,
      .XRD_STB, .XWR_STB, .RX_BYTE, .TX_BYTE, .TX_START, .EXT_IRQ, .POWERED_DOWN, .WAKE, .SOFT_RST,
      .PORT1_OUT, .PORT3_OUT, .PORT4_OUT, .PORT5_OUT, .PUSH_PULL);
   pdm_sram_model pdm_sram_model_inst (.CLK, .XDATA_ADDR, .XRD_STB, .XWR_STB, .last_adr, .n_strobe);
   initial forever #5 CLK = ~CLK;
   function automatic logic [16:0] map_fn(input logic [7:0] p, input logic [15:0] a);
      logic [16:0] e;
      e = (p[7:6] == 2'b11) ? 17'h0_0000 : 17'h0_8000 >> p[7:6];
      return ({1'b0, a} < 17'h1_0000 - e) ? {1'b0, a} : 17'({1'b0, a} + p[5:0] * e);
   endfunction
   function automatic logic [16:0] seen(input int s);
      logic [16:0] v [18];
      v = '{PROG_ADDR, 17'(IRDATA), 17'(TX_BYTE), 17'(XDATA_ADDR), 17'(REG_ADDR), 17'(WAKE), 17'(PORT1_OUT),
         17'(PORT3_OUT), 17'(PORT4_OUT), 17'(PORT5_OUT), 17'(PUSH_PULL[7:0]), 17'(PUSH_PULL[15:8]),
         17'(PUSH_PULL[23:16]), 17'(BIT_RDATA), 17'(XRD_STB), 17'(TX_START), 17'(SOFT_RST), 17'(XWR_STB)};
      return v[s];
   endfunction
   task automatic check(input string what, input logic [16:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // a note falls due at the falling edge after the registered output has updated
   task automatic note(input int sel, input logic [16:0] exp, input int lag = 2);
      notes.push_back('{ncyc + lag, sel, exp});
   endtask
   task automatic acc(input logic d, w, r, input logic [7:0] a, v = 8'h00);
      @(posedge CLK);
      IACC <= '{d, w, r, a, v};
      BACC <= '0;
   endtask
   task automatic wr(input logic [7:0] a, v);
      acc(1'b1, 1'b1, 1'b0, a, v);
   endtask
   task automatic rchk(input logic d, input logic [7:0] a, exp);
      acc(d, 1'b0, 1'b1, a);
      note(1, 17'(exp));
   endtask
   task automatic go(input logic [15:0] a);
      @(posedge CLK);
      IACC <= '0;
      PC <= a;
      note(0, map_fn(pg, a));
   endtask
   task automatic bop(input logic w, r, input logic [7:0] a, input logic v);
      @(posedge CLK);
      IACC <= '0;
      BACC <= '{w, r, a, v};
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(negedge CLK) begin
      ncyc++;
      while (notes.size() > 0 && notes[0].due <= ncyc) begin
         cur = notes.pop_front();
         check(nm[cur.sel], seen(cur.sel), cur.exp);
      end
   end
   always @(posedge CLK) begin
      ticks++;
      if (ticks == 1000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(72));
      repeat (2) @(posedge CLK);
      NRST <= 1'b1;
      rchk(1'b1, 8'h81, 8'h07);
      rchk(1'b1, 8'h80, 8'h00);
      pg = 8'h01;
      wr(8'h80, pg);
      go(16'h9F5A);
      for (int s = 0; s < 4; s++) begin
         pg = {2'(s), 6'($urandom)};
         wr(8'h80, pg);
         c = 17'h1_0000 - ((s == 3) ? 17'h0_0000 : 17'h0_8000 >> s);
         go(16'(c - 1));
         go(16'(c));
         go(16'($urandom));
      end
      x = 8'($urandom);
      acc(1'b0, 1'b1, 1'b0, 8'h85, x);
      wr(8'hF0, ~x); // software never writes empty register slots
      rchk(1'b0, 8'h85, x);
      rchk(1'b1, 8'h85, 8'h00);
      wr(8'h30, x);
      rchk(1'b0, 8'h30, x);
      wr(8'h21, 8'h00);
      bop(1'b1, 1'b0, 8'h0F, 1'b1);
      rchk(1'b1, 8'h21, 8'h80);
      wr(8'h90, x);
      bop(1'b0, 1'b1, 8'h93, 1'b0);
      note(13, 17'(x[3]));
      for (int i = 0; i < 7; i++) begin
         y = 8'($urandom);
         wr(adr_t[i], y);
         note(6 + i, 17'(y));
      end
      for (int b = 0; b < 4; b++) begin
         y = {3'($urandom), 2'(b), 3'($urandom)} & 8'hFE;
         wr(8'hD0, y);
         rchk(1'b1, 8'hD0, y);
         z = 3'($urandom);
         @(posedge CLK);
         REG_NUM <= z;
         note(4, {12'h000, 2'(b), z});
      end
      @(posedge CLK);
      FLAGS_WE <= 1'b1;
      FLAGS_IN <= 8'h08;
      SP_WE <= 1'b1;
      SP_IN <= 8'hFF;
      @(posedge CLK);
      FLAGS_WE <= 1'b0;
      SP_WE <= 1'b0;
      note(4, {12'h001, z});
      rchk(1'b1, 8'h81, 8'hFF);
      wr(8'h82, 8'h34);
      wr(8'h83, 8'h12);
      wr(8'hA2, 8'hDF);
      wr(8'h82, 8'hFF);
      wr(8'h83, 8'h56);
      rchk(1'b1, 8'hA2, 8'h19);
      note(3, 17'h0_56FF);
      @(posedge CLK);
      EXT_IRQ <= 1'b1;
      POWERED_DOWN <= 1'b1;
      PTR_INC <= 1'b1;
      note(5, 17'h0_0001);
      @(posedge CLK);
      PTR_INC <= 1'b0;
      note(3, 17'h0_5700);
      wr(8'hA2, 8'h00);
      note(5, 17'h0_0000, 3);
      note(3, 17'h0_1234, 3);
      rchk(1'b1, 8'h82, 8'h34);
      rchk(1'b1, 8'h99, ~x);
      RX_BYTE <= ~x;
      wr(8'h99, x);
      note(2, 17'(x));
      note(15, 17'h0_0001);
      acc(1'b0, 1'b1, 1'b0, 8'h99, ~x);
      note(2, 17'(x), 3);
      note(15, 17'h0_0000);
      wr(8'hA0, y);
      @(posedge CLK);
      IACC <= '0;
      XMOV_RI <= 1'b1;
      XRI_LOW <= x;
      XRD_REQ <= 1'b1;
      note(3, {1'b0, y, x});
      note(14, 17'h0_0001);
      note(17, 17'h0_0000);
      @(posedge CLK);
      XMOV_RI <= 1'b0;
      XRD_REQ <= 1'b0;
      repeat (3) @(posedge CLK);
      check("sram strobe address", {1'b0, last_adr}, {1'b0, y, x});
      check("sram strobe count", 17'(n_strobe), 17'h0_0001);
      wr(8'hA2, 8'h20);
      note(16, 17'h0_0001);
      repeat (3) @(posedge CLK);
      wrap_up();
   end
endmodule // pdm_top_test
`default_nettype wire
